// File: rtl/wdg_pkg.sv
package wdg_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int AXI_AW = 5;
   localparam logic [AXI_AW-1:0] OFS_OPTIONS_ONE = 5'h00;
   localparam logic [AXI_AW-1:0] OFS_OPTIONS_TWO = 5'h04;
   localparam logic [AXI_AW-1:0] OFS_RESET_CAUSE = 5'h08;
   localparam logic [AXI_AW-1:0] OFS_COUNT = 5'h0c;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int OPT1_ENABLE_BIT = 7;
   localparam int OPT1_TSEL_BIT = 6;
   localparam int OPT2_CLKSEL_BIT = 7;
   localparam int OPT2_WINDOW_BIT = 6;
   localparam int CAUSE_WDG_BIT = 5;
   localparam logic ENABLE_RST = 1'b1;
   localparam logic TSEL_RST = 1'b1;
   localparam logic CLKSEL_RST = 1'b0;
   localparam logic WINDOW_RST = 1'b0;

   // -----------------------------------------------------------------
   // Service keys, timeouts and bus answers
   // -----------------------------------------------------------------
   localparam logic [7:0] SVC_ARM_KEY = 8'h55;
   localparam logic [7:0] SVC_DONE_KEY = 8'haa;
   localparam int BUS_SHORT_CYC = 8192;
   localparam int BUS_LONG_CYC = 262144;
   localparam int LPO_SHORT_TICKS = 32;
   localparam int LPO_LONG_TICKS = 256;
   localparam logic [2:0] RST_PULSE_CYC = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic wdg_addr_ok(input logic [AXI_AW-1:0] addr);
      return (addr[AXI_AW-1:2] == OFS_OPTIONS_ONE[AXI_AW-1:2]) ||
             (addr[AXI_AW-1:2] == OFS_OPTIONS_TWO[AXI_AW-1:2]) ||
             (addr[AXI_AW-1:2] == OFS_RESET_CAUSE[AXI_AW-1:2]) ||
             (addr[AXI_AW-1:2] == OFS_COUNT[AXI_AW-1:2]);
   endfunction : wdg_addr_ok

endpackage : wdg_pkg

// File: rtl/wdg_pin_sync.sv
`timescale 1ns/1ps
module wdg_pin_sync (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_pin,
   output logic o_rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } wdg_sync_s;

   wdg_sync_s q_ff;
   wdg_sync_s nxt_q;

   // A change is believed only once the second and third stages agree.
   always_comb begin
      nxt_q = q_ff;
      nxt_q.s1 = i_pin;
      nxt_q.s2 = q_ff.s1;
      nxt_q.s3 = q_ff.s2;
      nxt_q.rise = 1'b0;
      if (q_ff.s2 == q_ff.s3) begin
         nxt_q.level = q_ff.s3;
         nxt_q.rise = q_ff.s3 && !q_ff.level;
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_rise = q_ff.rise;
endmodule : wdg_pin_sync

// File: rtl/wdg_axil_slave.sv
`timescale 1ns/1ps
module wdg_axil_slave
   import wdg_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [wdg_pkg::AXI_AW-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [wdg_pkg::AXI_AW-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_wr_pulse,
   output logic [wdg_pkg::AXI_AW-1:0] o_wr_addr,
   output logic [31:0] o_wr_data,
   output logic [3:0] o_wr_strb,
   output logic [wdg_pkg::AXI_AW-1:0] o_rd_addr,
   input wire logic [31:0] i_rd_data
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic have_aw;
      logic have_w;
      logic [AXI_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wr_pulse;
   } wdg_axi_s;

   wdg_axi_s q_ff;
   wdg_axi_s nxt_q;

   // Address and data are caught independently, so either may come first.
   always_comb begin
      nxt_q = q_ff;
      nxt_q.wr_pulse = 1'b0;
      if (q_ff.awready && i_awvalid) begin
         nxt_q.have_aw = 1'b1;
         nxt_q.waddr = i_awaddr;
      end
      if (q_ff.wready && i_wvalid) begin
         nxt_q.have_w = 1'b1;
         nxt_q.wdata = i_wdata;
         nxt_q.wstrb = i_wstrb;
      end
      if (q_ff.bvalid && i_bready) begin
         nxt_q.bvalid = 1'b0;
      end
      if (nxt_q.have_aw && nxt_q.have_w && !q_ff.bvalid) begin
         nxt_q.wr_pulse = 1'b1;
         nxt_q.bvalid = 1'b1;
         nxt_q.bresp = wdg_addr_ok(nxt_q.waddr) ? RESP_OKAY : RESP_SLVERR;
         nxt_q.have_aw = 1'b0;
         nxt_q.have_w = 1'b0;
      end
      nxt_q.awready = !nxt_q.have_aw && !nxt_q.bvalid;
      nxt_q.wready = !nxt_q.have_w && !nxt_q.bvalid;
      if (q_ff.arready && i_arvalid) begin
         nxt_q.rvalid = 1'b1;
         nxt_q.rdata = i_rd_data;
         nxt_q.rresp = wdg_addr_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (q_ff.rvalid && i_rready) begin
         nxt_q.rvalid = 1'b0;
      end
      nxt_q.arready = !nxt_q.rvalid;
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_awready = q_ff.awready;
   assign o_wready = q_ff.wready;
   assign o_bvalid = q_ff.bvalid;
   assign o_bresp = q_ff.bresp;
   assign o_arready = q_ff.arready;
   assign o_rvalid = q_ff.rvalid;
   assign o_rresp = q_ff.rresp;
   assign o_rdata = q_ff.rdata;
   assign o_wr_pulse = q_ff.wr_pulse;
   assign o_wr_addr = q_ff.waddr;
   assign o_wr_data = q_ff.wdata;
   assign o_wr_strb = q_ff.wstrb;
   assign o_rd_addr = i_araddr;
endmodule : wdg_axil_slave

// File: rtl/wdg_top.sv
`timescale 1ns/1ps
module wdg_top
   import wdg_pkg::*;
#(
   parameter bit P_ROBUST = 1'b1,
   parameter int P_SHORT_CYC = wdg_pkg::BUS_SHORT_CYC,
   parameter int P_LONG_CYC = wdg_pkg::BUS_LONG_CYC
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [wdg_pkg::AXI_AW-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [wdg_pkg::AXI_AW-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_lpo_clk,
   input wire logic i_debug_mode,
   input wire logic i_stop_mode,
   output logic o_wdg_reset
);
   import wdg_pkg::*;

   // -----------------------------------------------------------------
   // Timeout limits
   // -----------------------------------------------------------------
   localparam int P_CW = $clog2(P_LONG_CYC);
   localparam logic [P_CW-1:0] LIM_BUS_LONG = P_CW'(P_LONG_CYC - 1);
   localparam logic [P_CW-1:0] LIM_BUS_SHORT = P_CW'(P_SHORT_CYC - 1);
   localparam logic [P_CW-1:0] LIM_LPO_LONG = P_CW'(LPO_LONG_TICKS - 1);
   localparam logic [P_CW-1:0] LIM_LPO_SHORT = P_CW'(LPO_SHORT_TICKS - 1);

   typedef struct packed {
      logic enable;
      logic tsel;
      logic clksel;
      logic window;
      logic lock_one;
      logic lock_two;
      logic armed;
      logic cause;
      logic [P_CW-1:0] cnt;
      logic [2:0] rst_cnt;
      logic rst_out;
   } wdg_state_s;

   localparam wdg_state_s STATE_RST = '{enable: ENABLE_RST, tsel: TSEL_RST,
      clksel: CLKSEL_RST, window: WINDOW_RST, lock_one: 1'b0, lock_two: 1'b0,
      armed: 1'b0, cause: 1'b0, cnt: '0, rst_cnt: '0, rst_out: 1'b0};

   wdg_state_s q_ff;
   wdg_state_s nxt_q;

   logic wr_pulse;
   logic [AXI_AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [AXI_AW-1:0] rd_addr;
   logic [31:0] rd_data;
   logic lpo_rise;
   logic wr_ok;
   logic wr_opt1;
   logic wr_opt2;
   logic svc_wr;
   logic [7:0] wr_byte;
   logic halt;
   logic tick;
   logic rst_active;
   logic [P_CW-1:0] limit_m1;
   logic [P_CW-1:0] win_start;
   logic premature;
   logic bad_key;
   logic svc_done;
   logic expire;
   logic fire;

   // -----------------------------------------------------------------
   // Bus slave and oscillator input
   // -----------------------------------------------------------------
   wdg_axil_slave u_bus (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_wr_pulse(wr_pulse),
      .o_wr_addr(wr_addr),
      .o_wr_data(wr_data),
      .o_wr_strb(wr_strb),
      .o_rd_addr(rd_addr),
      .i_rd_data(rd_data)
   );

   // The oscillator is sampled here, so a dead bus clock also stops this
   // path; a fully independent watchdog would need its own clock domain.
   wdg_pin_sync u_lpo (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_lpo_clk),
      .o_rise(lpo_rise)
   );

   // -----------------------------------------------------------------
   // Decode and timeout selection
   // -----------------------------------------------------------------
   always_comb begin
      rst_active = q_ff.rst_cnt != 3'h0;
      wr_ok = wr_pulse && wr_strb[0] && !rst_active;
      wr_byte = wr_data[7:0];
      wr_opt1 = wr_ok && (wr_addr[AXI_AW-1:2] == OFS_OPTIONS_ONE[AXI_AW-1:2]);
      wr_opt2 = wr_ok && (wr_addr[AXI_AW-1:2] == OFS_OPTIONS_TWO[AXI_AW-1:2]);
      svc_wr = wr_ok && (wr_addr[AXI_AW-1:2] == OFS_RESET_CAUSE[AXI_AW-1:2]);
      halt = i_debug_mode || i_stop_mode;
      tick = q_ff.clksel ? lpo_rise : 1'b1;
      if (q_ff.clksel) begin
         limit_m1 = q_ff.tsel ? LIM_LPO_LONG : LIM_LPO_SHORT;
      end else begin
         limit_m1 = q_ff.tsel ? LIM_BUS_LONG : LIM_BUS_SHORT;
      end
      win_start = limit_m1 - (limit_m1 >> 2);
      premature = P_ROBUST && q_ff.window && !q_ff.clksel &&
                  q_ff.enable && (q_ff.cnt < win_start);
      bad_key = P_ROBUST && svc_wr && (wr_byte != SVC_ARM_KEY) &&
                (wr_byte != SVC_DONE_KEY);
      svc_done = svc_wr && (!P_ROBUST ||
                 ((wr_byte == SVC_DONE_KEY) && q_ff.armed));
      expire = q_ff.enable && !halt && !svc_done && tick &&
               (q_ff.cnt == limit_m1) && !rst_active;
      fire = expire || bad_key || (svc_wr && premature);
   end

   // -----------------------------------------------------------------
   // Register read mux
   // -----------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0;
      case (rd_addr[AXI_AW-1:2])
         OFS_OPTIONS_ONE[AXI_AW-1:2]: begin
            rd_data[OPT1_ENABLE_BIT] = q_ff.enable;
            rd_data[OPT1_TSEL_BIT] = q_ff.tsel;
         end
         OFS_OPTIONS_TWO[AXI_AW-1:2]: begin
            rd_data[OPT2_CLKSEL_BIT] = q_ff.clksel;
            rd_data[OPT2_WINDOW_BIT] = q_ff.window;
         end
         OFS_RESET_CAUSE[AXI_AW-1:2]: begin
            rd_data[CAUSE_WDG_BIT] = q_ff.cause;
         end
         OFS_COUNT[AXI_AW-1:2]: begin
            rd_data[P_CW-1:0] = q_ff.cnt;
         end
         default: begin
            rd_data = 32'h0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Watchdog state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_q = q_ff;
      if (rst_active) begin
         nxt_q.rst_cnt = q_ff.rst_cnt - 3'h1;
         nxt_q.rst_out = q_ff.rst_cnt != 3'h1;
      end else if (fire) begin
         // The watchdog reset reinitialises all but the cause flag and the reset pulse counter and output.
         nxt_q = STATE_RST;
         nxt_q.cause = 1'b1;
         nxt_q.rst_cnt = RST_PULSE_CYC;
         nxt_q.rst_out = 1'b1;
      end else begin
         if (wr_opt1 && !q_ff.lock_one) begin
            nxt_q.enable = wr_byte[OPT1_ENABLE_BIT];
            nxt_q.tsel = wr_byte[OPT1_TSEL_BIT];
            nxt_q.lock_one = 1'b1;
         end
         if (P_ROBUST && wr_opt2 && !q_ff.lock_two) begin
            nxt_q.clksel = wr_byte[OPT2_CLKSEL_BIT];
            nxt_q.window = wr_byte[OPT2_WINDOW_BIT];
            nxt_q.lock_two = 1'b1;
         end
         if (svc_wr) begin
            nxt_q.armed = wr_byte == SVC_ARM_KEY;
         end
         if (!q_ff.enable) begin
            nxt_q.cnt = '0;
         end else if (halt) begin
            if (q_ff.clksel) begin
               nxt_q.cnt = '0;
            end
         end else if (svc_done) begin
            nxt_q.cnt = '0;
         end else if (tick) begin
            nxt_q.cnt = q_ff.cnt + P_CW'(1);
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q_ff <= STATE_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_wdg_reset = q_ff.rst_out;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   timeout_reset_a: assert property (expire |=> o_wdg_reset ##3 o_wdg_reset ##1 !o_wdg_reset)
      else $error("Timeout did not raise a four-cycle reset.");
   count_limit_a: assert property (q_ff.cnt <= limit_m1)
      else $error("Count ran past the selected timeout.");
   opt_lock_a: assert property (wr_opt1 && q_ff.lock_one && !fire |=> $stable(q_ff.enable) && $stable(q_ff.tsel))
      else $error("Locked options register changed.");
   enable_default_a: assert property ($fell(o_wdg_reset) |-> q_ff.enable && !q_ff.lock_one)
      else $error("Enable not set after watchdog reset.");
   disabled_quiet_a: assert property (!q_ff.enable && !svc_wr |=> !$rose(o_wdg_reset) && q_ff.cnt == '0)
      else $error("Disabled watchdog counted or reset.");
   simple_clear_a: assert property (!P_ROBUST && svc_wr |=> q_ff.cnt == '0)
      else $error("Service write did not clear the count.");
   pair_service_a: assert property (svc_wr && q_ff.armed && wr_byte == SVC_DONE_KEY && !fire |=> q_ff.cnt == '0 && !q_ff.armed)
      else $error("Ordered pair did not restart the count.");
   bad_key_a: assert property (bad_key && !rst_active |=> o_wdg_reset && q_ff.cause)
      else $error("Wrong key did not reset at once.");
   opt2_lock_a: assert property (wr_opt2 && q_ff.lock_two && !fire |=> $stable(q_ff.clksel) && $stable(q_ff.window))
      else $error("Locked second options register changed.");
   bus_hold_a: assert property (!q_ff.clksel && q_ff.enable && halt && !fire && !rst_active |=> $stable(q_ff.cnt))
      else $error("Count moved while halted on bus clock.");
   lpo_clear_a: assert property (q_ff.clksel && halt && !fire && !rst_active |=> q_ff.cnt == '0)
      else $error("Count not cleared while halted on oscillator.");
   window_early_a: assert property (svc_wr && premature && !rst_active |=> o_wdg_reset)
      else $error("Early windowed service did not reset.");
   lpo_no_window_a: assert property (q_ff.clksel |-> !premature)
      else $error("Window active with oscillator source.");
   lone_done_a: assert property (P_ROBUST && svc_wr && !q_ff.armed && wr_byte == SVC_DONE_KEY &&
      q_ff.enable && !halt && !fire && tick |=> q_ff.cnt != '0)
      else $error("Lone second key restarted the count.");

   timeout_c: cover property (expire);
   service_c: cover property (svc_done && q_ff.cnt != '0);
   bad_key_c: cover property (bad_key);
   lpo_halt_c: cover property (q_ff.clksel && halt);
endmodule : wdg_top

// File: verification/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bench for the watchdog, robust and simple variants with shortened bus limits
// ----------------------------------------------------------------------
module tb_top;
   import wdg_pkg::*;
   localparam int SHORT_CYC = 64;
   localparam int LONG_CYC = 256;
   logic i_mclk;
   logic i_sys_rst;
   logic [AXI_AW-1:0] i_awaddr;
   logic i_awvalid;
   logic [31:0] i_wdata;
   logic [3:0] i_wstrb;
   logic i_wvalid;
   logic i_bready;
   logic [AXI_AW-1:0] i_araddr;
   logic i_arvalid;
   logic i_rready;
   logic i_lpo_clk;
   logic i_debug_mode;
   logic i_stop_mode;
   logic o_awready;
   logic o_wready;
   logic [1:0] o_bresp;
   logic o_bvalid;
   logic o_arready;
   logic [31:0] o_rdata;
   logic [1:0] o_rresp;
   logic o_rvalid;
   logic o_wdg_reset;
   logic o_wdg_reset_s;
   logic lpo_run;
   logic [1:0] resp;
   logic [31:0] rdv;
   logic [31:0] cnt_a;
   int n_mismatch;
   int tests_run;
   int n;
   int w;

   wdg_top #(.P_ROBUST(1'b1), .P_SHORT_CYC(SHORT_CYC), .P_LONG_CYC(LONG_CYC)) uut (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .i_lpo_clk(i_lpo_clk), .i_debug_mode(i_debug_mode), .i_stop_mode(i_stop_mode),
      .o_wdg_reset(o_wdg_reset)
   );

   // The simple variant shares every input; its bus outputs are left open and only its reset output is watched.
   wdg_top #(.P_ROBUST(1'b0), .P_SHORT_CYC(SHORT_CYC), .P_LONG_CYC(LONG_CYC)) uut_s (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(),
      .o_bresp(), .o_bvalid(), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(),
      .o_rdata(), .o_rresp(), .o_rvalid(), .i_rready(i_rready),
      .i_lpo_clk(i_lpo_clk), .i_debug_mode(i_debug_mode), .i_stop_mode(i_stop_mode),
      .o_wdg_reset(o_wdg_reset_s)
   );

   // ----------------------------------------------------------------------
   // Clocks
   // ----------------------------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   // The oscillator stands far slower than the bus clock; its edges fall on falling bus edges, off the rising ones.
   initial begin
      i_lpo_clk = 1'b0;
      forever begin
         #500;
         if (lpo_run) i_lpo_clk = ~i_lpo_clk;
      end
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   task automatic do_reset();
      @(posedge i_mclk);
      i_sys_rst <= 1'b1;
      repeat (20) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
   endtask : do_reset

   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] v);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge i_mclk);
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= {24'h0, v};
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge i_mclk);
         if (!aw_ok && o_awready === 1'b1) begin
            i_awvalid <= 1'b0;
            aw_ok = 1'b1;
         end
         if (!w_ok && o_wready === 1'b1) begin
            i_wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      while (o_bvalid !== 1'b1) @(posedge i_mclk);
      resp = o_bresp;
      i_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [AXI_AW-1:0] a);
      @(posedge i_mclk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(posedge i_mclk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      i_rready <= 1'b1;
      do @(posedge i_mclk); while (o_rvalid !== 1'b1);
      rdv = o_rdata;
      resp = o_rresp;
      i_rready <= 1'b0;
   endtask : rd

   // Counts bus cycles until the reset request shows, giving up at the limit.
   task automatic wait_rst(input int lim);
      n = 0;
      while (o_wdg_reset !== 1'b1 && n < lim) begin
         @(posedge i_mclk);
         n++;
      end
   endtask : wait_rst

   // ----------------------------------------------------------------------
   // Watchdog of the run
   // ----------------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge i_mclk);
      n_mismatch++;
      close_out();
   end

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      tests_run = 0;
      lpo_run = 1'b0;
      i_sys_rst = 1'b1;
      i_awaddr = '0;
      i_awvalid = 1'b0;
      i_wdata = '0;
      i_wstrb = 4'h1;
      i_wvalid = 1'b0;
      i_bready = 1'b0;
      i_araddr = '0;
      i_arvalid = 1'b0;
      i_rready = 1'b0;
      i_debug_mode = 1'b0;
      i_stop_mode = 1'b0;
      do_reset();
      // Reset values and an unmapped place.
      rd(OFS_OPTIONS_ONE);
      chk(rdv, 32'hc0);
      rd(OFS_OPTIONS_TWO);
      chk(rdv, 32'h0);
      rd(OFS_RESET_CAUSE);
      chk(rdv, 32'h0);
      rd(5'h10);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      chk(rdv, 32'h0);
      wr(5'h14, 8'h55);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      // Unserviced long timeout, pulse width and cause flag.
      wait_rst(1000);
      chk(32'(n inside {[LONG_CYC-24:LONG_CYC+4]}), 32'h1);
      w = 0;
      while (o_wdg_reset === 1'b1) begin
         @(posedge i_mclk);
         w++;
      end
      chk(32'(w), 32'h4);
      rd(OFS_RESET_CAUSE);
      chk(rdv, 32'h20);
      // Short period, first write locks the options.
      wr(OFS_OPTIONS_ONE, 8'h80);
      wr(OFS_OPTIONS_ONE, 8'hc0);
      rd(OFS_OPTIONS_ONE);
      chk(rdv, 32'h80);
      wr(OFS_RESET_CAUSE, SVC_ARM_KEY);
      wr(OFS_RESET_CAUSE, SVC_DONE_KEY);
      wait_rst(1000);
      chk(32'(n inside {[SHORT_CYC-4:SHORT_CYC+4]}), 32'h1);
      // A lone completing key does not restart; the ordered pair does.
      do_reset();
      repeat (30) @(posedge i_mclk);
      rd(OFS_COUNT);
      cnt_a = rdv;
      wr(OFS_RESET_CAUSE, SVC_DONE_KEY);
      rd(OFS_COUNT);
      chk(32'(rdv > cnt_a), 32'h1);
      cnt_a = rdv;
      wr(OFS_RESET_CAUSE, SVC_ARM_KEY);
      wr(OFS_RESET_CAUSE, SVC_DONE_KEY);
      rd(OFS_COUNT);
      chk(32'(rdv < cnt_a), 32'h1);
      // Any other key resets at once.
      do_reset();
      wr(OFS_RESET_CAUSE, 8'h12);
      wait_rst(10);
      chk(32'(n <= 3), 32'h1);
      // Simple variant: any write to the cause register clears its count.
      do_reset();
      repeat (200) @(posedge i_mclk);
      wr(OFS_RESET_CAUSE, SVC_ARM_KEY);
      wait_rst(100);
      chk(32'(n inside {[30:70]}), 32'h1);
      chk({31'h0, o_wdg_reset_s}, 32'h0);
      // Bus source holds its count in debug and in stop.
      for (int m = 0; m < 2; m++) begin
         do_reset();
         i_debug_mode <= (m == 0);
         i_stop_mode <= (m == 1);
         rd(OFS_COUNT);
         cnt_a = rdv;
         repeat (300) @(posedge i_mclk);
         rd(OFS_COUNT);
         chk(rdv, cnt_a);
         chk({31'h0, o_wdg_reset}, 32'h0);
         i_debug_mode <= 1'b0;
         i_stop_mode <= 1'b0;
         repeat (10) @(posedge i_mclk);
         rd(OFS_COUNT);
         chk(32'(rdv > cnt_a), 32'h1);
      end
      // Clearing the enable bit stops all timeout resets.
      do_reset();
      wr(OFS_OPTIONS_ONE, 8'h40);
      wait_rst(600);
      chk(32'(n), 32'd600);
      // Windowed service: too early resets, in the last quarter restarts.
      do_reset();
      wr(OFS_OPTIONS_TWO, 8'h40);
      wr(OFS_RESET_CAUSE, SVC_ARM_KEY);
      wait_rst(10);
      chk(32'(n <= 3), 32'h1);
      do_reset();
      wr(OFS_OPTIONS_TWO, 8'h40);
      repeat (200) @(posedge i_mclk);
      wr(OFS_RESET_CAUSE, SVC_ARM_KEY);
      wr(OFS_RESET_CAUSE, SVC_DONE_KEY);
      rd(OFS_COUNT);
      chk(32'(rdv < 32'd16), 32'h1);
      wait_rst(200);
      chk(32'(n), 32'd200);
      // Oscillator source: slow count, cleared in debug, times out on ticks.
      do_reset();
      lpo_run = 1'b1;
      wr(OFS_OPTIONS_TWO, 8'h80);
      repeat (400) @(posedge i_mclk);
      rd(OFS_COUNT);
      chk(32'(rdv inside {[32'd15:32'd25]}), 32'h1);
      i_debug_mode <= 1'b1;
      repeat (60) @(posedge i_mclk);
      rd(OFS_COUNT);
      chk(rdv, 32'h0);
      i_debug_mode <= 1'b0;
      wait_rst(6000);
      chk(32'(n inside {[5050:5200]}), 32'h1);
      lpo_run = 1'b0;
      close_out();
   end
endmodule : tb_top
